// ---- dv/cdb_core_debug_properties.sv ----
/* Assertions on the pin behaviour of cdb_core_debug.
   Assumes one clock and the bind at the foot of this file. */
`timescale 1ns/10ps
module cdb_core_debug_properties (
  input wire logic clock,
  input wire logic rstn,
  input wire logic test_reset_n,
  input wire logic clkEn,
  input wire logic debug_enable_in,
  input wire logic exValid,
  input wire logic exCondPass,
  input wire logic instr_commit_pulse,
  input wire logic instr_not_executed,
  input wire logic blockXferActive,
  input wire logic multi_transfer_hint,
  input wire logic fast_irq_n,
  input wire logic normal_irq_n,
  input wire logic fiqDisable,
  input wire logic irqDisable,
  input wire logic fiqTake,
  input wire logic irqTake,
  input wire logic lockedSeq,
  input wire logic lock,
  input wire logic accessIsData,
  input wire logic accessPriv,
  input wire logic accessWrite,
  input wire logic accessActive,
  input wire logic [1:0] access_protection,
  input wire logic write,
  input wire logic [31:0] rdata,
  input wire logic [31:0] readDataCaptured,
  input wire logic debug_request_in,
  input wire logic debugStateOut,
  input wire logic comms_rx_full,
  input wire logic comms_tx_empty
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn || !test_reset_n);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence reqHeld;
    debug_request_in && debug_enable_in && clkEn && !debugStateOut;
  endsequence
  commit_pulse_a: assert property (clkEn && exValid |=> instr_commit_pulse)
    else $error("no commit pulse");
  commit_once_a: assert property (clkEn && !exValid |=> !instr_commit_pulse)
    else $error("stray commit pulse");
  not_exec_a: assert property (clkEn && exValid |=> instr_not_executed == !$past(exCondPass))
    else $error("not executed flag wrong");
  multi_hint_a: assert property (clkEn |=> multi_transfer_hint == $past(blockXferActive))
    else $error("multi transfer hint wrong");
  lock_level_a: assert property (clkEn |=> lock == $past(lockedSeq))
    else $error("lock wrong");
  prot_code_a: assert property (clkEn |=> access_protection == $past({accessPriv, accessIsData}))
    else $error("protection code wrong");
  write_dir_a: assert property (clkEn |=> write == $past(accessWrite))
    else $error("write direction wrong");
  read_capture_a: assert property (clkEn && accessActive && !write |=> readDataCaptured == $past(rdata))
    else $error("read data not captured");
  fast_irq_a: assert property (fiqTake |-> $past(!fast_irq_n && !fiqDisable))
    else $error("fast take without request");
  normal_irq_a: assert property (irqTake |-> $past(!normal_irq_n && !irqDisable) && !fiqTake)
    else $error("normal take wrong");
  debug_entry_a: assert property (reqHeld [*3] |=> debugStateOut)
    else $error("debug state not entered");
  flag_gate_a: assert property (!debug_enable_in |-> !comms_rx_full && !comms_tx_empty)
    else $error("comms flags not gated");
endmodule : cdb_core_debug_properties

bind cdb_core_debug cdb_core_debug_properties i_cdb_core_debug_properties (.*);

// ---- dv/cdb_core_debug_tb.sv ----
/* Self-checking bench for cdb_core_debug.
   Assumes the checker is bound in and the host model drives the test port. */
`timescale 1ns/10ps
`include "cdb_map.svh"
module cdb_core_debug_tb;
  logic clock, rstn, clkEn, debug_enable_in, test_reset_n, test_clk_enable, test_serial_in;
  logic test_mode_select, test_serial_out, test_out_enable_n, comms_rx_full, comms_tx_empty;
  logic coreRxRead, coreTxWrite, debug_request_in, debugStateOut, debugExit, watchBreak;
  logic exValid, exCondPass, instr_commit_pulse, instr_not_executed, blockXferActive;
  logic multi_transfer_hint, fast_irq_n, normal_irq_n, fiqDisable, irqDisable, fiqTake, irqTake;
  logic lockedSeq, lock, accessIsData, accessPriv, accessWrite, accessActive, write, shiftEnOk;
  logic [1:0] watch_ext_cond, watchExtSel, watchEnable, watch_match_out, access_protection;
  logic [31:0] coreTxData, coreRxData, watchAddr0, watchAddr1, busAddr, rdata, readDataCaptured;
  logic [31:0] got;
  int fails, checks, cyc;

  cdb_core_debug i_cdb_core_debug (.*);
  cdb_jtag_host i_cdb_jtag_host (.*);

  always #50 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic nc(input int n);
    repeat (n) @(negedge clock);
  endtask : nc
  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim

  initial begin
    clock = 1'b0;
    rstn = 1'b0;
    test_reset_n = 1'b0;
    clkEn = 1'b1;
    debug_enable_in = 1'b1;
    fast_irq_n = 1'b1;
    normal_irq_n = 1'b1;
    {coreRxRead, coreTxWrite, debug_request_in, debugExit, exValid, exCondPass} = 6'h0;
    {blockXferActive, fiqDisable, irqDisable, lockedSeq, accessIsData} = 5'h0;
    {accessPriv, accessWrite, accessActive, watch_ext_cond, watchExtSel, watchEnable} = 9'h0;
    {coreTxData, watchAddr0, watchAddr1, busAddr, rdata} = 160'h0;
    nc(8);
    rstn = 1'b1;
    test_reset_n = 1'b1;
    nc(1);
    chk({instr_commit_pulse, lock, write, fiqTake, irqTake, debugStateOut}, 32'h0, "reset out");
    chk({comms_rx_full, comms_tx_empty, test_out_enable_n}, 32'h3, "reset debug");
    $display("reset test done");
    // ----------------------------------------------------------------
    // execute-stage and access qualifiers, every code
    // ----------------------------------------------------------------
    for (int i = 0; i < 8; i++) begin
      {exCondPass, accessPriv, accessIsData} = i[2:0];
      {accessWrite, lockedSeq, blockXferActive} = i[2:0];
      exValid = 1'b1;
      nc(1);
      chk(instr_commit_pulse, 32'h1, "commit");
      chk(instr_not_executed, {31'h0, !i[2]}, "not exec");
      chk(access_protection, i[1:0], "prot");
      chk({write, lock, multi_transfer_hint}, i[2:0], "qual");
    end
    exValid = 1'b0;
    accessWrite = 1'b0;
    accessActive = 1'b1;
    rdata = 32'hA5C3_0F1E;
    nc(1);
    chk(instr_commit_pulse, 32'h0, "commit held");
    nc(1);
    chk(readDataCaptured, 32'hA5C3_0F1E, "read");
    accessWrite = 1'b1;
    rdata = 32'h1357_9BDF;
    nc(1);
    rdata = 32'h2468_ACE0;
    nc(1);
    chk(readDataCaptured, 32'h1357_9BDF, "write cycle");
    accessActive = 1'b0;
    $display("qualifier test done");
    // ----------------------------------------------------------------
    // interrupts: priority, refusal while held, disables
    // ----------------------------------------------------------------
    fast_irq_n = 1'b0;
    normal_irq_n = 1'b0;
    nc(1);
    chk({fiqTake, irqTake}, 32'h2, "fast wins");
    nc(1);
    chk({fiqTake, irqTake}, 32'h0, "held refused");
    fast_irq_n = 1'b1;
    normal_irq_n = 1'b1;
    nc(1);
    normal_irq_n = 1'b0;
    nc(1);
    chk({fiqTake, irqTake}, 32'h1, "normal");
    normal_irq_n = 1'b1;
    {fiqDisable, irqDisable} = 2'h3;
    nc(1);
    {fast_irq_n, normal_irq_n} = 2'h0;
    nc(1);
    chk({fiqTake, irqTake}, 32'h0, "disabled");
    {fast_irq_n, normal_irq_n, fiqDisable, irqDisable} = 4'hC;
    $display("interrupt test done");
    // ----------------------------------------------------------------
    // watchpoint rangeout and debug enable gating
    // ----------------------------------------------------------------
    {busAddr, watchAddr0, watchAddr1} = {3{32'h0000_4000}};
    watchExtSel = 2'h2;
    nc(1);
    chk(watch_match_out, 32'h1, "range ext");
    watch_ext_cond = 2'h2;
    nc(1);
    chk(watch_match_out, 32'h3, "range both");
    watchEnable = 2'h1;
    nc(1);
    watchEnable = 2'h0;
    chk(watchBreak, 32'h1, "break");
    nc(1);
    chk(debugStateOut, 32'h1, "break entry");
    debugExit = 1'b1;
    nc(1);
    debugExit = 1'b0;
    debug_enable_in = 1'b0;
    nc(1);
    chk({watch_match_out, comms_rx_full, comms_tx_empty}, 32'h0, "gated");
    debug_enable_in = 1'b1;
    busAddr = 32'h0;
    $display("watch test done");
    // ----------------------------------------------------------------
    // serial port: identity and comms both ways
    // ----------------------------------------------------------------
    coreTxData = 32'h5A5A_C3C3;
    coreTxWrite = 1'b1;
    nc(1);
    coreTxWrite = 1'b0;
    chk(comms_tx_empty, 32'h0, "tx full");
    i_cdb_jtag_host.reset_tap();
    i_cdb_jtag_host.scan(1'b1, 4, `CDB_IR_IDCODE, got);
    chk(got[3:0], `CDB_IR_CAPTURE, "ir capture");
    i_cdb_jtag_host.scan(1'b0, 32, 32'h0, got);
    chk(got, `CDB_IDCODE, "identity");
    i_cdb_jtag_host.scan(1'b1, 4, `CDB_IR_COMMS, got);
    i_cdb_jtag_host.scan(1'b0, 32, 32'h0F0F_1234, got);
    chk(got, 32'h5A5A_C3C3, "tx word");
    // the rx flag follows the update strobe by one edge
    nc(1);
    chk({comms_rx_full, comms_tx_empty}, 32'h3, "flags");
    chk(coreRxData, 32'h0F0F_1234, "rx word");
    chk({shiftEnOk, test_out_enable_n}, 32'h3, "tdo enable");
    coreRxRead = 1'b1;
    nc(1);
    coreRxRead = 1'b0;
    chk(comms_rx_full, 32'h0, "rx read");
    $display("serial test done");
    // ----------------------------------------------------------------
    // debug request sync, exit and test reset
    // ----------------------------------------------------------------
    debug_request_in = 1'b1;
    nc(2);
    chk(debugStateOut, 32'h0, "sync early");
    nc(1);
    chk(debugStateOut, 32'h1, "debug entry");
    debug_request_in = 1'b0;
    nc(3);
    debugExit = 1'b1;
    nc(1);
    debugExit = 1'b0;
    chk(debugStateOut, 32'h0, "debug exit");
    coreTxWrite = 1'b1;
    nc(1);
    coreTxWrite = 1'b0;
    test_reset_n = 1'b0;
    nc(1);
    // lock belongs to the core reset, so the arbiter still sees it held
    chk({comms_tx_empty, test_out_enable_n, lock}, 32'h7, "test reset");
    test_reset_n = 1'b1;
    $display("debug test done");
    end_sim();
  end
endmodule : cdb_core_debug_tb

// ---- dv/cdb_jtag_host.sv ----
/* Debug controller model: drives the serial test port by enable ticks.
   Assumes a free core clock; ticks are launched at the falling edge. */
`timescale 1ns/10ps
module cdb_jtag_host (
  input wire logic clock,
  input wire logic test_serial_out,
  input wire logic test_out_enable_n,
  output logic test_clk_enable,
  output logic test_mode_select,
  output logic test_serial_in,
  output logic shiftEnOk
);
  logic enSeen;
  initial begin
    test_clk_enable = 1'b0;
    test_mode_select = 1'b1;
    test_serial_in = 1'b0;
    shiftEnOk = 1'b1;
  end
  // one enable pulse per tick, then a quiet cycle
  task automatic tick(input logic m, input logic d, output logic q);
    @(negedge clock);
    q = test_serial_out;
    enSeen = test_out_enable_n;
    test_mode_select = m;
    test_serial_in = d;
    test_clk_enable = 1'b1;
    @(negedge clock);
    test_clk_enable = 1'b0;
    // toggled so a stale bit never passes for live data
    test_serial_in = ~d;
  endtask : tick
  task automatic reset_tap();
    logic q;
    repeat (5) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask : reset_tap
  // from idle through shift and update back to idle
  task automatic scan(input logic isIr, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    dout = 32'h0;
    tick(1'b1, 1'b0, q);
    if (isIr) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
      if (enSeen !== 1'b0) shiftEnOk = 1'b0;
    end
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask : scan
endmodule : cdb_jtag_host

// ---- rtl/cdb_core_debug.sv ----
/*
 * Debug, interrupt and memory qualifier pin logic of a 32-bit core.
 * Assumes the pipeline supplies execute-stage events and access
 * attributes as synchronous levels; the debug controller pulses the
 * test clock enable once per tick.
 */
`timescale 1ns/10ps
module cdb_core_debug
  import cdb_pkg::*;
#(
  parameter int ADDR_WIDTH = 32,
  parameter int DATA_WIDTH = 32
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic debug_enable_in,
  input wire logic test_reset_n,
  input wire logic test_clk_enable,
  input wire logic test_serial_in,
  input wire logic test_mode_select,
  output logic test_serial_out,
  output logic test_out_enable_n,
  output logic comms_rx_full,
  output logic comms_tx_empty,
  input wire logic coreRxRead,
  input wire logic coreTxWrite,
  input wire logic [DATA_WIDTH-1:0] coreTxData,
  output logic [DATA_WIDTH-1:0] coreRxData,
  input wire logic debug_request_in,
  output logic debugStateOut,
  input wire logic debugExit,
  input wire logic [1:0] watch_ext_cond,
  input wire logic [1:0] watchExtSel,
  input wire logic [1:0] watchEnable,
  input wire logic [ADDR_WIDTH-1:0] watchAddr0,
  input wire logic [ADDR_WIDTH-1:0] watchAddr1,
  input wire logic [ADDR_WIDTH-1:0] busAddr,
  output logic [1:0] watch_match_out,
  output logic watchBreak,
  input wire logic exValid,
  input wire logic exCondPass,
  output logic instr_commit_pulse,
  output logic instr_not_executed,
  input wire logic blockXferActive,
  output logic multi_transfer_hint,
  input wire logic fast_irq_n,
  input wire logic normal_irq_n,
  input wire logic fiqDisable,
  input wire logic irqDisable,
  output logic fiqTake,
  output logic irqTake,
  input wire logic lockedSeq,
  output logic lock,
  input wire logic accessIsData,
  input wire logic accessPriv,
  input wire logic accessWrite,
  input wire logic accessActive,
  output logic [1:0] access_protection,
  output logic write,
  input wire logic [31:0] rdata,
  output logic [31:0] readDataCaptured
);
  logic [31:0] rxWord;
  logic rxStrobe;
  logic txTaken;
  logic hostDbgReq;
  logic tapTdo;
  logic tapTdoEnN;
  logic reqSync;
  logic [1:0] match;
  logic rxFull_r;
  logic txFull_r;
  logic [DATA_WIDTH-1:0] txData_r;
  logic debugState_r;
  cdb_irq_t irqState_r;

  function automatic logic qualMatch(input logic addrHit, input logic sel,
                                     input logic ext);
    qualMatch = addrHit & (~sel | ext);
  endfunction : qualMatch

  // ----------------------------------------------------------------
  // test access port, gated by debug enable
  // ----------------------------------------------------------------
  cdb_tap u_tap (
    .clock(clock),
    .testResetN(test_reset_n),
    .clkEn(clkEn & debug_enable_in),
    .tckEn(test_clk_enable),
    .tms(test_mode_select),
    .tdi(test_serial_in),
    .txWord(txData_r),
    .tdo(tapTdo),
    .tdoEnN(tapTdoEnN),
    .rxWord(rxWord),
    .rxStrobe(rxStrobe),
    .txTaken(txTaken),
    .hostDbgReq(hostDbgReq)
  );

  assign test_serial_out = debug_enable_in & tapTdo;
  assign test_out_enable_n = ~debug_enable_in | tapTdoEnN;

  // ----------------------------------------------------------------
  // comms channel buffers
  // ----------------------------------------------------------------
  // new word wins over a same-cycle read so none is lost
  always_ff @(posedge clock or negedge test_reset_n) begin
    if (!test_reset_n) begin
      rxFull_r <= 1'b0;
      coreRxData <= '0;
    end else if (clkEn) begin
      if (rxStrobe) begin
        rxFull_r <= 1'b1;
        coreRxData <= rxWord[DATA_WIDTH-1:0];
      end else if (coreRxRead) begin
        rxFull_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge test_reset_n) begin
    if (!test_reset_n) begin
      txFull_r <= 1'b0;
      txData_r <= '0;
    end else if (clkEn) begin
      if (coreTxWrite && !txFull_r) begin
        txFull_r <= 1'b1;
        txData_r <= coreTxData;
      end else if (txTaken) begin
        txFull_r <= 1'b0;
      end
    end
  end

  assign comms_rx_full = debug_enable_in & rxFull_r;
  assign comms_tx_empty = debug_enable_in & ~txFull_r;

  // ----------------------------------------------------------------
  // debug request and debug state
  // ----------------------------------------------------------------
  cdb_sync u_reqSync (
    .clock(clock),
    .rstn(test_reset_n),
    .clkEn(clkEn),
    .din(debug_request_in),
    .dout(reqSync)
  );

  always_ff @(posedge clock or negedge test_reset_n) begin
    if (!test_reset_n) begin
      debugState_r <= 1'b0;
    end else if (clkEn) begin
      if (debug_enable_in && (reqSync || hostDbgReq || watchBreak)) begin
        debugState_r <= 1'b1;
      end else if (debugExit) begin
        debugState_r <= 1'b0;
      end
    end
  end

  assign debugStateOut = debug_enable_in & debugState_r;

  // ----------------------------------------------------------------
  // watchpoint units
  // ----------------------------------------------------------------
  always_comb begin
    match[0] = qualMatch(busAddr == watchAddr0, watchExtSel[0],
                         watch_ext_cond[0] & debug_enable_in);
    match[1] = qualMatch(busAddr == watchAddr1, watchExtSel[1],
                         watch_ext_cond[1] & debug_enable_in);
  end

  // rangeout ignores the unit enable; break honours it
  always_ff @(posedge clock or negedge test_reset_n) begin
    if (!test_reset_n) begin
      watch_match_out <= 2'h0;
      watchBreak <= 1'b0;
    end else if (clkEn) begin
      watch_match_out <= match & {2{debug_enable_in}};
      watchBreak <= |(match & watchEnable) & debug_enable_in;
    end
  end

  // ----------------------------------------------------------------
  // pipeline trace qualifiers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      instr_commit_pulse <= 1'b0;
      instr_not_executed <= 1'b0;
      multi_transfer_hint <= 1'b0;
    end else if (clkEn) begin
      instr_commit_pulse <= exValid;
      instr_not_executed <= exValid & ~exCondPass;
      multi_transfer_hint <= blockXferActive;
    end
  end

  // ----------------------------------------------------------------
  // interrupts: fast has priority; level held by source until ack
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fiqTake <= 1'b0;
      irqTake <= 1'b0;
      irqState_r <= CDB_IRQ_NONE;
    end else if (clkEn) begin
      fiqTake <= 1'b0;
      irqTake <= 1'b0;
      case (irqState_r)
        CDB_IRQ_NONE: begin
          if (!fast_irq_n && !fiqDisable) begin
            fiqTake <= 1'b1;
            irqState_r <= CDB_IRQ_TAKEN;
          end else if (!normal_irq_n && !irqDisable) begin
            irqTake <= 1'b1;
            irqState_r <= CDB_IRQ_TAKEN;
          end
        end
        CDB_IRQ_TAKEN: begin
          // wait for the level to be released before the next take
          if (fast_irq_n && normal_irq_n) begin
            irqState_r <= CDB_IRQ_NONE;
          end
        end
        default: irqState_r <= CDB_IRQ_NONE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // memory qualifiers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      lock <= 1'b0;
      access_protection <= 2'h0;
      write <= 1'b0;
    end else if (clkEn) begin
      lock <= lockedSeq;
      access_protection[`CDB_PROT_DATA_BIT] <= accessIsData;
      access_protection[`CDB_PROT_PRIV_BIT] <= accessPriv;
      write <= accessWrite;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      readDataCaptured <= 32'h0000_0000;
    end else if (clkEn && accessActive && !write) begin
      readDataCaptured <= rdata;
    end
  end
endmodule : cdb_core_debug

// ---- rtl/cdb_map.svh ----
/*
 * Constants for the core debug, interrupt and bus qualifier block.
 * Assumes inclusion by the package and the testbench only.
 */
`ifndef CDB_MAP_SVH
`define CDB_MAP_SVH

// ----------------------------------------------------------------
// test access port instruction register
// ----------------------------------------------------------------
`define CDB_IR_WIDTH 4
`define CDB_IR_RESET 4'hE
`define CDB_IR_BYPASS 4'hF
`define CDB_IR_IDCODE 4'hE
`define CDB_IR_COMMS 4'h2
`define CDB_IR_DBGREQ 4'h3
`define CDB_IR_CAPTURE 4'h1

// ----------------------------------------------------------------
// identity and comms data
// ----------------------------------------------------------------
// arbitrary identity value
`define CDB_IDCODE 32'h1234_5671
`define CDB_COMMS_WIDTH 32

// ----------------------------------------------------------------
// protection field positions
// ----------------------------------------------------------------
`define CDB_PROT_DATA_BIT 0
`define CDB_PROT_PRIV_BIT 1

`endif

// ---- rtl/cdb_pkg.sv ----
/*
 * Types for the core debug, interrupt and bus qualifier block.
 * Assumes the constant header is on the include path.
 */
package cdb_pkg;
  `include "cdb_map.svh"

  // ----------------------------------------------------------------
  // test access port states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [15:0] {
    CDB_TLR = 16'h0001,
    CDB_RTI = 16'h0002,
    CDB_SDR = 16'h0004,
    CDB_CDR = 16'h0008,
    CDB_SHDR = 16'h0010,
    CDB_E1DR = 16'h0020,
    CDB_PDR = 16'h0040,
    CDB_E2DR = 16'h0080,
    CDB_UDR = 16'h0100,
    CDB_SIR = 16'h0200,
    CDB_CIR = 16'h0400,
    CDB_SHIR = 16'h0800,
    CDB_E1IR = 16'h1000,
    CDB_PIR = 16'h2000,
    CDB_E2IR = 16'h4000,
    CDB_UIR = 16'h8000
  } cdb_tap_t;

  typedef enum logic [1:0] {
    CDB_IRQ_NONE = 2'h1,
    CDB_IRQ_TAKEN = 2'h2
  } cdb_irq_t;
endpackage : cdb_pkg

// ---- rtl/cdb_sync.sv ----
/*
 * Two-stage synchroniser for a level from another clock domain.
 * Assumes one destination clock; first stage feeds only the second.
 */
`timescale 1ns/10ps
module cdb_sync (
  input wire logic clock,
  input wire logic rstn,
  input wire logic clkEn,
  input wire logic din,
  output logic dout
);
  logic meta_r;
  logic sync_r;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else if (clkEn) begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  assign dout = sync_r;
endmodule : cdb_sync

// ---- rtl/cdb_tap.sv ----
/*
 * Test access port controller with bypass, identity, comms and request
 * data registers. Assumes tck enable pulses once per test clock tick,
 * synchronous to the core clock.
 */
`timescale 1ns/10ps
module cdb_tap
  import cdb_pkg::*;
(
  input wire logic clock,
  input wire logic testResetN,
  input wire logic clkEn,
  input wire logic tckEn,
  input wire logic tms,
  input wire logic tdi,
  input wire logic [31:0] txWord,
  output logic tdo,
  output logic tdoEnN,
  output logic [31:0] rxWord,
  output logic rxStrobe,
  output logic txTaken,
  output logic hostDbgReq
);
  cdb_tap_t state_r;
  cdb_tap_t state_nxt;
  logic [`CDB_IR_WIDTH-1:0] irShift_r;
  logic [`CDB_IR_WIDTH-1:0] ir_r;
  logic [31:0] dr_r;
  logic tdo_r;
  logic tdoEnN_r;
  logic adv;

  assign adv = clkEn & tckEn;

  // capture value of the data register selected by the instruction
  function automatic logic [31:0] captureWord(input logic [`CDB_IR_WIDTH-1:0] ir,
                                              input logic [31:0] tx);
    if (ir == `CDB_IR_IDCODE) begin
      captureWord = `CDB_IDCODE;
    end else if (ir == `CDB_IR_COMMS) begin
      captureWord = tx;
    end else begin
      captureWord = 32'h0000_0000;
    end
  endfunction : captureWord

  logic [31:0] capWord;
  assign capWord = captureWord(ir_r, txWord);

  // ----------------------------------------------------------------
  // state walk
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CDB_TLR: state_nxt = tms ? CDB_TLR : CDB_RTI;
      CDB_RTI: state_nxt = tms ? CDB_SDR : CDB_RTI;
      CDB_SDR: state_nxt = tms ? CDB_SIR : CDB_CDR;
      CDB_CDR: state_nxt = tms ? CDB_E1DR : CDB_SHDR;
      CDB_SHDR: state_nxt = tms ? CDB_E1DR : CDB_SHDR;
      CDB_E1DR: state_nxt = tms ? CDB_UDR : CDB_PDR;
      CDB_PDR: state_nxt = tms ? CDB_E2DR : CDB_PDR;
      CDB_E2DR: state_nxt = tms ? CDB_UDR : CDB_SHDR;
      CDB_UDR: state_nxt = tms ? CDB_SDR : CDB_RTI;
      CDB_SIR: state_nxt = tms ? CDB_TLR : CDB_CIR;
      CDB_CIR: state_nxt = tms ? CDB_E1IR : CDB_SHIR;
      CDB_SHIR: state_nxt = tms ? CDB_E1IR : CDB_SHIR;
      CDB_E1IR: state_nxt = tms ? CDB_UIR : CDB_PIR;
      CDB_PIR: state_nxt = tms ? CDB_E2IR : CDB_PIR;
      CDB_E2IR: state_nxt = tms ? CDB_UIR : CDB_SHIR;
      CDB_UIR: state_nxt = tms ? CDB_SDR : CDB_RTI;
      default: state_nxt = CDB_TLR;
    endcase
  end

  always_ff @(posedge clock or negedge testResetN) begin
    if (!testResetN) begin
      state_r <= CDB_TLR;
    end else if (adv) begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge testResetN) begin
    if (!testResetN) begin
      irShift_r <= `CDB_IR_RESET;
      ir_r <= `CDB_IR_RESET;
    end else if (adv) begin
      if (state_r == CDB_TLR) begin
        ir_r <= `CDB_IR_RESET;
      end else if (state_r == CDB_CIR) begin
        irShift_r <= `CDB_IR_CAPTURE;
      end else if (state_r == CDB_SHIR) begin
        irShift_r <= {tdi, irShift_r[`CDB_IR_WIDTH-1:1]};
      end else if (state_r == CDB_UIR) begin
        ir_r <= irShift_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // data register and comms hand-off
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge testResetN) begin
    if (!testResetN) begin
      dr_r <= 32'h0000_0000;
      rxWord <= 32'h0000_0000;
      rxStrobe <= 1'b0;
      txTaken <= 1'b0;
      hostDbgReq <= 1'b0;
    end else if (clkEn) begin
      // pulses last one enabled cycle, so a frozen consumer cannot miss them
      rxStrobe <= 1'b0;
      txTaken <= 1'b0;
      if (adv) begin
        if (state_r == CDB_CDR) begin
          dr_r <= capWord;
          txTaken <= (ir_r == `CDB_IR_COMMS);
        end else if (state_r == CDB_SHDR) begin
          if (ir_r == `CDB_IR_BYPASS) begin
            dr_r <= {31'h0000_0000, tdi};
          end else if (ir_r == `CDB_IR_DBGREQ) begin
            dr_r <= {31'h0000_0000, tdi};
          end else begin
            dr_r <= {tdi, dr_r[31:1]};
          end
        end else if (state_r == CDB_UDR) begin
          if (ir_r == `CDB_IR_COMMS) begin
            rxWord <= dr_r;
            rxStrobe <= 1'b1;
          end else if (ir_r == `CDB_IR_DBGREQ) begin
            hostDbgReq <= dr_r[0];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // serial out, updated with the shift so the enable frames the data
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge testResetN) begin
    if (!testResetN) begin
      tdo_r <= 1'b0;
      tdoEnN_r <= 1'b1;
    end else if (adv) begin
      // show the bit that the shift register holds after this same tick
      if (state_nxt == CDB_SHDR) begin
        if (state_r == CDB_CDR) begin
          tdo_r <= capWord[0];
        end else if (state_r != CDB_SHDR) begin
          tdo_r <= dr_r[0];
        end else if (ir_r == `CDB_IR_BYPASS || ir_r == `CDB_IR_DBGREQ) begin
          tdo_r <= tdi;
        end else begin
          tdo_r <= dr_r[1];
        end
        tdoEnN_r <= 1'b0;
      end else if (state_nxt == CDB_SHIR) begin
        if (state_r == CDB_CIR) begin
          tdo_r <= 1'(`CDB_IR_CAPTURE);
        end else if (state_r == CDB_SHIR) begin
          tdo_r <= irShift_r[1];
        end else begin
          tdo_r <= irShift_r[0];
        end
        tdoEnN_r <= 1'b0;
      end else begin
        tdo_r <= 1'b0;
        tdoEnN_r <= 1'b1;
      end
    end
  end

  assign tdo = tdo_r;
  assign tdoEnN = tdoEnN_r;
endmodule : cdb_tap
